// ---- hw/seq_defines.vh ----
`ifndef SEQ_DEFINES_VH
`define SEQ_DEFINES_VH

// Register byte offsets
`define OFS_CONTROL_0          8'h00
`define OFS_CONTROL_1          8'h04
`define OFS_STATUS             8'h08
`define OFS_SAMPLE_TIME_A      8'h0C
`define OFS_SAMPLE_TIME_B      8'h10
`define OFS_SEQ_LIST_0         8'h14
`define OFS_SEQ_LIST_1         8'h18
`define OFS_SEQ_LIST_2         8'h1C
`define OFS_HIGH_LIMIT         8'h20
`define OFS_LOW_LIMIT          8'h24
`define OFS_RESULT             8'h28

// control_reg_0 fields
`define C0_MON_CH_LSB          0
`define C0_EOC_IE              5
`define C0_MON_IE              6
`define C0_SCAN                8
`define C0_MON_SINGLE          9
`define C0_DISC                11
`define C0_GROUP_LSB           13
`define C0_MON_EN              23

// control_reg_1 fields
`define C1_ON                  0
`define C1_CONT                1
`define C1_DMA                 8
`define C1_ALIGN               11
`define C1_TRIG_LSB            17
`define C1_TRIG_EN             20
`define C1_SW_START            22
`define C1_INT_CH              23
`define C1_RES_LSB             24

// Status fields
`define ST_MON_FLAG            0
`define ST_EOC_FLAG            1
`define ST_BUSY                4

// Reset value and software trigger select code
`define HIGH_LIMIT_RESET       12'hfff
`define TRIG_SOFTWARE          3'h7

// Timing: 12.5 converter cycles is counted as 13 whole cycles
`define CONV_CYCLES_12         8'h0d

`endif

// ---- hw/sample_timer.v ----
`default_nettype none

// Counts one channel's sample plus conversion time
module sample_timer
(
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        clear,
    // Control
    input  wire        start,
    input  wire [2:0]  code,
    input  wire [1:0]  resolution,
    // Status
    output reg         done
);

`include "seq_defines.vh"

reg  [8:0] count_reg;
reg        run_reg;

// Sample code to whole cycles (half cycle rounded up)
function [8:0] sample_cycles;
    input [2:0] c;
    begin
        case (c)
            3'h0:    sample_cycles = 9'h002;
            3'h1:    sample_cycles = 9'h008;
            3'h2:    sample_cycles = 9'h00e;
            3'h3:    sample_cycles = 9'h01c;
            3'h4:    sample_cycles = 9'h02a;
            3'h5:    sample_cycles = 9'h038;
            3'h6:    sample_cycles = 9'h048;
            default: sample_cycles = 9'h0f0;
        endcase
    end
endfunction

wire [8:0] conv_cycles = {1'b0, `CONV_CYCLES_12} - {6'h00, resolution, 1'b0};

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        count_reg <= 9'h000;
        run_reg   <= 1'b0;
        done      <= 1'b0;
    end
    else if (clear)
    begin
        count_reg <= 9'h000;
        run_reg   <= 1'b0;
        done      <= 1'b0;
    end
    else
    begin
        done <= 1'b0;
        if (start)
        begin
            count_reg <= sample_cycles(code) + conv_cycles - 9'h001;
            run_reg   <= 1'b1;
        end
        else if (run_reg)
        begin
            if (count_reg == 9'h001)
            begin
                run_reg <= 1'b0;
                done    <= 1'b1;
            end
            count_reg <= count_reg - 9'h001;
        end
    end
end

endmodule

`default_nettype wire

// ---- hw/sequence_control.v ----
`default_nettype none

module sequence_control
#(
    parameter TRIGGERS = 7
)
(
    // Clock and reset
    input  wire                hclk,
    input  wire                hresetn,
    // AHB-Lite slave
    input  wire                hsel,
    input  wire [7:0]          haddr,
    input  wire [1:0]          htrans,
    input  wire                hwrite,
    input  wire [2:0]          hsize,
    input  wire [31:0]         hwdata,
    input  wire                hready,
    output reg                 hreadyout,
    output reg                 hresp,
    output reg  [31:0]         hrdata,
    // Trigger inputs
    input  wire [TRIGGERS-1:0] trigger_in,
    // Converter core
    output reg                 analog_power,
    output reg                 internal_channel_power,
    output reg                 sample_start,
    output reg  [4:0]          sample_channel,
    input  wire [11:0]         core_result,
    // Requests
    output reg                 dma_request,
    output reg                 irq
);

`include "seq_defines.vh"

localparam ST_IDLE = 3'b001;
localparam ST_CONV = 3'b010;
localparam ST_NEXT = 3'b100;

////////////////////////////////////////////////////////////////////////////////
// Registers

reg  [31:0] control_reg_0;
reg  [31:0] control_reg_1;
reg  [29:0] sample_time_reg_a;
reg  [29:0] sample_time_reg_b;
reg  [31:0] sequence_list_reg_0;
reg  [29:0] sequence_list_reg_1;
reg  [29:0] sequence_list_reg_2;
reg  [11:0] monitor_high_limit;
reg  [11:0] monitor_low_limit;
reg  [15:0] result_reg;
reg         end_flag_reg;
reg         monitor_event_flag;
reg  [2:0]  state_reg;
reg  [3:0]  index_reg;
reg  [3:0]  group_reg;
reg  [TRIGGERS-1:0] trig_prev_reg;
reg         wr_pend_reg;
reg  [7:0]  addr_reg;

wire       converter_on           = control_reg_1[`C1_ON];
wire       continuous_enable      = control_reg_1[`C1_CONT];
wire       dma_enable             = control_reg_1[`C1_DMA];
wire       alignment_select       = control_reg_1[`C1_ALIGN];
wire [2:0] trigger_source_select  = control_reg_1[`C1_TRIG_LSB+2:`C1_TRIG_LSB];
wire       external_trigger_enable = control_reg_1[`C1_TRIG_EN];
wire       software_start         = control_reg_1[`C1_SW_START];
wire       internal_channel_enable = control_reg_1[`C1_INT_CH];
wire [1:0] resolution             = control_reg_1[`C1_RES_LSB+1:`C1_RES_LSB];
wire       scan_enable            = control_reg_0[`C0_SCAN];
wire       discontinuous_enable   = control_reg_0[`C0_DISC];
wire [2:0] group_count            = control_reg_0[`C0_GROUP_LSB+2:`C0_GROUP_LSB];
wire       routine_monitor_enable = control_reg_0[`C0_MON_EN];
wire       monitor_single_channel = control_reg_0[`C0_MON_SINGLE];
wire [4:0] monitor_channel_select = control_reg_0[`C0_MON_CH_LSB+4:`C0_MON_CH_LSB];
wire       end_of_conversion_irq_enable = control_reg_0[`C0_EOC_IE];
wire       monitor_event_irq_enable = control_reg_0[`C0_MON_IE];
wire [3:0] sequence_length        = sequence_list_reg_0[23:20];

////////////////////////////////////////////////////////////////////////////////
// Helpers

// Channel number of list entry i
function [4:0] list_channel;
    input [3:0]  i;
    input [29:0] l0;
    input [29:0] l1;
    input [29:0] l2;
    reg   [29:0] word;
    reg   [3:0]  pos;
    begin
        word = (i < 4'd6) ? l2 : ((i < 4'd12) ? l1 : l0);
        pos  = (i < 4'd6) ? i : ((i < 4'd12) ? (i - 4'd6) : (i - 4'd12));
        list_channel = word[pos*5 +: 5];
    end
endfunction

// Sample time code for a channel
function [2:0] channel_code;
    input [4:0]  ch;
    input [29:0] a;
    input [29:0] b;
    begin
        if (ch < 5'd10)
            channel_code = b[ch*3 +: 3];
        else if (ch < 5'd18)
            channel_code = a[(ch-5'd10)*3 +: 3];
        else
            channel_code = 3'h0;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Trigger selection

wire [TRIGGERS-1:0] trig_rise = trigger_in & ~trig_prev_reg;
wire ext_edge = external_trigger_enable && (trigger_source_select != `TRIG_SOFTWARE) &&
                trig_rise[trigger_source_select];
wire sw_trig  = software_start && (trigger_source_select == `TRIG_SOFTWARE);
wire trigger  = ext_edge | sw_trig;

////////////////////////////////////////////////////////////////////////////////
// Timer and result handling

wire       conv_done;
wire [4:0] cur_channel = list_channel(index_reg, sequence_list_reg_0[29:0],
                                      sequence_list_reg_1, sequence_list_reg_2);
wire [4:0] first_channel = list_channel(4'h0, sequence_list_reg_0[29:0],
                                        sequence_list_reg_1, sequence_list_reg_2);
wire       last_entry  = (index_reg == sequence_length);
wire       group_end   = (group_reg == {1'b0, group_count});

sample_timer u_timer
(
    .hclk       (hclk),
    .hresetn    (hresetn),
    .clear      (!converter_on),
    .start      (sample_start),
    .code       (channel_code(sample_channel, sample_time_reg_a, sample_time_reg_b)),
    .resolution (resolution),
    .done       (conv_done)
);

// Raw result taken from the core unmasked at every resolution
wire [11:0] raw_result = core_result;
wire        watched = !monitor_single_channel || (sample_channel == monitor_channel_select);
wire        out_of_range = (raw_result > monitor_high_limit) ||
                           (raw_result < monitor_low_limit);
wire        mon_hit = conv_done && routine_monitor_enable && watched && out_of_range;

reg [15:0] aligned;
always @*
begin
    if (!alignment_select)
        aligned = {4'h0, raw_result};
    else if (resolution == 2'b11)
        aligned = {2'b00, raw_result[5:0], 8'h00};
    else
        aligned = {raw_result, 4'h0};
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer

wire seq_end = conv_done && last_entry;

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        state_reg     <= ST_IDLE;
        index_reg     <= 4'h0;
        group_reg     <= 4'h0;
        sample_start  <= 1'b0;
        sample_channel <= 5'h00;
        dma_request   <= 1'b0;
        result_reg    <= 16'h0000;
        trig_prev_reg <= {TRIGGERS{1'b0}};
    end
    else if (!converter_on)
    begin
        state_reg     <= ST_IDLE;
        index_reg     <= 4'h0;
        group_reg     <= 4'h0;
        sample_start  <= 1'b0;
        dma_request   <= 1'b0;
        trig_prev_reg <= trigger_in;
    end
    else
    begin
        trig_prev_reg <= trigger_in;
        sample_start  <= 1'b0;
        dma_request   <= 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (trigger)
                begin
                    // Only discontinuous groups resume mid-list
                    sample_channel <= discontinuous_enable ? cur_channel : first_channel;
                    if (!discontinuous_enable)
                        index_reg  <= 4'h0;
                    sample_start   <= 1'b1;
                    group_reg      <= 4'h0;
                    state_reg      <= ST_CONV;
                end
            end
            ST_CONV:
            begin
                if (conv_done)
                begin
                    result_reg  <= aligned;
                    dma_request <= dma_enable;
                    state_reg   <= ST_NEXT;
                end
            end
            ST_NEXT:
            begin
                state_reg <= ST_IDLE;
                if (last_entry || !(scan_enable || discontinuous_enable))
                begin
                    index_reg <= 4'h0;
                    if (continuous_enable)
                    begin
                        sample_channel <= list_channel(4'h0, sequence_list_reg_0[29:0],
                                                       sequence_list_reg_1, sequence_list_reg_2);
                        sample_start   <= 1'b1;
                        group_reg      <= 4'h0;
                        state_reg      <= ST_CONV;
                    end
                end
                else if (discontinuous_enable && group_end)
                    index_reg <= index_reg + 4'h1;
                else
                begin
                    index_reg      <= index_reg + 4'h1;
                    group_reg      <= group_reg + 4'h1;
                    sample_channel <= list_channel(index_reg + 4'h1, sequence_list_reg_0[29:0],
                                                   sequence_list_reg_1, sequence_list_reg_2);
                    sample_start   <= 1'b1;
                    state_reg      <= ST_CONV;
                end
            end
            default:
                state_reg <= ST_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Bus slave and register writes

wire addr_phase = hsel && htrans[1] && hready;
wire clear_eoc  = wr_pend_reg && (addr_reg == `OFS_STATUS) && !hwdata[`ST_EOC_FLAG];
wire clear_mon  = wr_pend_reg && (addr_reg == `OFS_STATUS) && !hwdata[`ST_MON_FLAG];

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        wr_pend_reg         <= 1'b0;
        addr_reg            <= 8'h00;
        control_reg_0       <= 32'h0000_0000;
        control_reg_1       <= 32'h0000_0000;
        sample_time_reg_a   <= 30'h0000_0000;
        sample_time_reg_b   <= 30'h0000_0000;
        sequence_list_reg_0 <= 32'h0000_0000;
        sequence_list_reg_1 <= 30'h0000_0000;
        sequence_list_reg_2 <= 30'h0000_0000;
        monitor_high_limit  <= `HIGH_LIMIT_RESET;
        monitor_low_limit   <= 12'h000;
        end_flag_reg        <= 1'b0;
        monitor_event_flag  <= 1'b0;
        hreadyout           <= 1'b1;
        hresp               <= 1'b0;
        hrdata              <= 32'h0000_0000;
        analog_power        <= 1'b0;
        internal_channel_power <= 1'b0;
        irq                 <= 1'b0;
    end
    else
    begin
        wr_pend_reg <= addr_phase && hwrite;
        if (addr_phase)
            addr_reg <= {haddr[7:2], 2'b00};
        if (addr_phase && !hwrite)
        begin
            case ({haddr[7:2], 2'b00})
                `OFS_CONTROL_0:     hrdata <= control_reg_0;
                `OFS_CONTROL_1:     hrdata <= control_reg_1;
                `OFS_STATUS:        hrdata <= {27'h000_0000, (state_reg != ST_IDLE), 2'b00,
                                               end_flag_reg, monitor_event_flag};
                `OFS_SAMPLE_TIME_A: hrdata <= {2'b00, sample_time_reg_a};
                `OFS_SAMPLE_TIME_B: hrdata <= {2'b00, sample_time_reg_b};
                `OFS_SEQ_LIST_0:    hrdata <= sequence_list_reg_0;
                `OFS_SEQ_LIST_1:    hrdata <= {2'b00, sequence_list_reg_1};
                `OFS_SEQ_LIST_2:    hrdata <= {2'b00, sequence_list_reg_2};
                `OFS_HIGH_LIMIT:    hrdata <= {20'h0_0000, monitor_high_limit};
                `OFS_LOW_LIMIT:     hrdata <= {20'h0_0000, monitor_low_limit};
                `OFS_RESULT:        hrdata <= {16'h0000, result_reg};
                default:            hrdata <= 32'h0000_0000;
            endcase
        end
        // Self-clear first so a simultaneous register write wins
        if (sw_trig && state_reg == ST_IDLE && converter_on)
            control_reg_1[`C1_SW_START] <= 1'b0;
        if (wr_pend_reg)
        begin
            case (addr_reg)
                `OFS_CONTROL_0:     control_reg_0 <= hwdata;
                `OFS_CONTROL_1:     control_reg_1 <= hwdata;
                `OFS_SAMPLE_TIME_A: sample_time_reg_a <= hwdata[29:0];
                `OFS_SAMPLE_TIME_B: sample_time_reg_b <= hwdata[29:0];
                `OFS_SEQ_LIST_0:    sequence_list_reg_0 <= {8'h00, hwdata[23:0]};
                `OFS_SEQ_LIST_1:    sequence_list_reg_1 <= hwdata[29:0];
                `OFS_SEQ_LIST_2:    sequence_list_reg_2 <= hwdata[29:0];
                `OFS_HIGH_LIMIT:    monitor_high_limit <= hwdata[11:0];
                `OFS_LOW_LIMIT:     monitor_low_limit <= hwdata[11:0];
                default:            hrdata <= hrdata;
            endcase
        end
        // Set wins over a simultaneous clear
        if (seq_end && (scan_enable || discontinuous_enable || 1'b1))
            end_flag_reg <= 1'b1;
        else if (clear_eoc)
            end_flag_reg <= 1'b0;
        if (mon_hit)
            monitor_event_flag <= 1'b1;
        else if (clear_mon)
            monitor_event_flag <= 1'b0;
        analog_power           <= converter_on;
        internal_channel_power <= internal_channel_enable && converter_on;
        irq <= (end_flag_reg && end_of_conversion_irq_enable) ||
               (monitor_event_flag && monitor_event_irq_enable);
    end
end

endmodule

`default_nettype wire

// ---- tb/sequence_control_asserts.sv ----
`default_nettype none
module sequence_control_asserts
(
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Converter and requests
    input wire logic        analog_power,
    input wire logic        internal_channel_power,
    input wire logic        sample_start,
    input wire logic [4:0]  sample_channel,
    input wire logic        dma_request,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic rd_phase;
    logic wr_phase;
    assign rd_phase = hsel && htrans[1] && hready && !hwrite;
    assign wr_phase = hsel && htrans[1] && hready && hwrite;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////////
    // Shortest conversion is 9 cycles: channel held, no restart, no request
    sequence conv_busy;
        (!sample_start && $stable(sample_channel))[*8];
    endsequence
    sequence no_dma;
        (!dma_request)[*8];
    endsequence
    okay_resp_a: assert property (!hresp) else $error("error response seen");
    zero_wait_a: assert property (hreadyout) else $error("wait state inserted");
    start_pulse_a: assert property (sample_start |=> conv_busy) else $error("start not held off");
    conv_length_a: assert property (sample_start |=> no_dma) else $error("request too early");
    dma_pulse_a: assert property (dma_request |=> !dma_request) else $error("request too long");
    off_idle_a: assert property (!analog_power |-> !sample_start && !dma_request) else $error("active while off");
    int_power_a: assert property (internal_channel_power |-> analog_power) else $error("sensor on while off");
    read_hold_a: assert property (!$past(rd_phase) |-> $stable(hrdata)) else $error("read data changed");
    irq_clear_a: assert property ($fell(irq) |-> $past(wr_phase, 2) || $past(wr_phase, 3))
        else $error("interrupt fell without write");
endmodule

bind sequence_control sequence_control_asserts i_sequence_control_asserts
(
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .analog_power(analog_power),
    .internal_channel_power(internal_channel_power), .sample_start(sample_start),
    .sample_channel(sample_channel), .dma_request(dma_request), .irq(irq)
);
`default_nettype wire

// ---- tb/converter_core_model.sv ----
`default_nettype none
module converter_core_model
(
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Sequencer side
    input wire logic        sample_start,
    input wire logic [4:0]  sample_channel,
    output logic     [11:0] core_result
);
    timeunit 1ns;
    timeprecision 100ps;
    // Raw value identifies the channel; held until the next start
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            core_result <= 12'h000;
        else if (sample_start)
            core_result <= {3'h0, sample_channel, 4'h0};
    end
endmodule
`default_nettype wire

// ---- tb/test_adc_sequence_control.sv ----
`default_nettype none
`include "seq_defines.vh"
module test_adc_sequence_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic             hclk, hresetn, hsel, hwrite;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    logic [7:0]       haddr;
    logic [31:0]      hwdata;
    logic [6:0]       trigger_in;
    wire logic        hready, hreadyout, hresp, analog_power, internal_channel_power;
    wire logic        sample_start, dma_request, irq;
    wire logic [4:0]  sample_channel;
    wire logic [11:0] core_result;
    wire logic [31:0] hrdata;
    int               miscompares, tests_run, dmas;
    logic [4:0]       chan_q[$];
    longint           when_q[$];
    logic [31:0]      exp_ch[4] = '{32'h0000_0003, 32'h0000_0005, 32'h0000_0007, 32'h0000_0009};
    // Single select bit, high limit, low limit, expected monitor flag
    logic [11:0]      mon_tab[4][4] = '{'{12'h200, 12'h070, 12'h000, 12'h000},
        '{12'h200, 12'h06f, 12'h000, 12'h001}, '{12'h000, 12'hfff, 12'h030, 12'h000},
        '{12'h000, 12'hfff, 12'h031, 12'h001}};

    function automatic logic [31:0] bv(input int n);
        return 32'h0000_0001 << n;
    endfunction
    localparam logic [31:0] C1_BASE = bv(`C1_ON) | bv(`C1_DMA) | bv(`C1_TRIG_EN);
    localparam logic [31:0] SW_GO = (32'h0000_0007 << `C1_TRIG_LSB) | bv(`C1_SW_START);

    assign hready = hreadyout;
    always #12.5 hclk = ~hclk;

    sequence_control #(.TRIGGERS(7)) i_sequence_control
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .trigger_in(trigger_in), .analog_power(analog_power),
        .internal_channel_power(internal_channel_power), .sample_start(sample_start),
        .sample_channel(sample_channel), .core_result(core_result), .dma_request(dma_request), .irq(irq)
    );
    converter_core_model i_converter_core_model
    (
        .hclk(hclk), .hresetn(hresetn), .sample_start(sample_start), .sample_channel(sample_channel),
        .core_result(core_result)
    );

    ////////////////////////////////////////////////////////////////////////
    // Records every started channel and every transfer request
    always @(posedge hclk)
    begin
        if (sample_start === 1'b1)
        begin
            chan_q.push_back(sample_channel);
            when_q.push_back($time);
        end
        if (dma_request === 1'b1)
            dmas++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t ns got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(a, 1'b0, 32'h0000_0000, r);
        check(r, e);
    endtask
    task automatic wait_dma(input int n);
        for (int i = 0; i < 3000 && dmas < n; i++)
            @(posedge hclk);
    endtask
    task automatic wait_irq;
        for (int i = 0; i < 3000 && irq !== 1'b1; i++)
            @(posedge hclk);
    endtask
    task automatic pulse(input int k);
        @(posedge hclk);
        trigger_in[k] <= 1'b1;
        repeat (2) @(posedge hclk);
        trigger_in[k] <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #500_000;
        miscompares++;
        tally_and_finish;
    end

    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        trigger_in = 7'h00;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(`OFS_HIGH_LIMIT, 32'h0000_0fff);
        rdc(8'h3c, 32'h0000_0000);
        check({31'h0, analog_power}, 32'h0000_0000);
        wr(`OFS_CONTROL_1, bv(`C1_ON) | bv(`C1_INT_CH));
        repeat (2) @(posedge hclk);
        check({31'h0, internal_channel_power}, 32'h0000_0001);
        wr(`OFS_CONTROL_1, bv(`C1_ON));
        repeat (2) @(posedge hclk);
        check({31'h0, internal_channel_power}, 32'h0000_0000);
        $display("test reset_power done");
        wr(`OFS_SEQ_LIST_2, 32'h0000_0003 | (32'h0000_0005 << 5) | (32'h0000_0007 << 10) | (32'h0000_0009 << 15));
        wr(`OFS_SEQ_LIST_0, 32'h0000_0003 << 20);
        wr(`OFS_SAMPLE_TIME_B, 32'h0000_0001 << 15);
        wr(`OFS_CONTROL_0, bv(`C0_SCAN) | bv(`C0_EOC_IE));
        wr(`OFS_CONTROL_1, C1_BASE | SW_GO);
        wait_irq;
        check({31'h0, irq}, 32'h0000_0001);
        for (int k = 0; k < 4; k++)
            check({27'h0, chan_q[k]}, exp_ch[k]);
        check(dmas, 32'h0000_0004);
        check(32'((when_q[2] + when_q[0] - 2 * when_q[1]) / 25), 32'h0000_0006);
        rdc(`OFS_RESULT, 32'h0000_0090);
        rdc(`OFS_STATUS, 32'h0000_0002);
        wr(`OFS_STATUS, 32'h0000_0000);
        rdc(`OFS_STATUS, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
        $display("test scan done");
        chan_q.delete();
        dmas = 0;
        wr(`OFS_CONTROL_1, C1_BASE | bv(`C1_CONT) | SW_GO);
        wait_dma(6);
        for (int k = 4; k < 6; k++)
            check({27'h0, chan_q[k]}, exp_ch[k - 4]);
        wr(`OFS_CONTROL_1, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        chan_q.delete();
        repeat (60) @(posedge hclk);
        check(chan_q.size(), 32'h0000_0000);
        check({31'h0, analog_power}, 32'h0000_0000);
        wr(`OFS_STATUS, 32'h0000_0000);
        $display("test continuous done");
        wr(`OFS_CONTROL_0, bv(`C0_DISC) | bv(`C0_GROUP_LSB) | bv(`C0_EOC_IE));
        dmas = 0;
        for (int t = 0; t < 7; t++)
        begin
            wr(`OFS_CONTROL_1, C1_BASE | (32'(t) << `C1_TRIG_LSB));
            pulse((t + 1) % 7);
            repeat (30) @(posedge hclk);
            check(chan_q.size(), 32'(2 * t));
            pulse(t);
            wait_dma(2 * t + 2);
            repeat (5) @(posedge hclk);
            check(chan_q.size(), 32'(2 * t + 2));
            check({27'h0, chan_q[2 * t]}, exp_ch[(2 * t) % 4]);
            check({27'h0, chan_q[2 * t + 1]}, exp_ch[(2 * t + 1) % 4]);
            check({31'h0, irq}, 32'(t % 2));
            wr(`OFS_STATUS, 32'h0000_0000);
        end
        $display("test discontinuous done");
        for (int m = 0; m < 4; m++)
        begin
            wr(`OFS_HIGH_LIMIT, {20'h0, mon_tab[m][1]});
            wr(`OFS_LOW_LIMIT, {20'h0, mon_tab[m][2]});
            wr(`OFS_CONTROL_0, bv(`C0_SCAN) | bv(`C0_EOC_IE) | bv(`C0_MON_EN) | {20'h0, mon_tab[m][0]} | 32'h0000_0007);
            wr(`OFS_CONTROL_1, C1_BASE | bv(`C1_ALIGN) | SW_GO);
            wait_irq;
            rdc(`OFS_STATUS, 32'h0000_0002 | {20'h0, mon_tab[m][3]});
            rdc(`OFS_RESULT, 32'h0000_0900);
            wr(`OFS_STATUS, 32'h0000_0000);
        end
        $display("test monitor done");
        chan_q.delete();
        when_q.delete();
        wr(`OFS_CONTROL_1, C1_BASE | bv(`C1_ALIGN) | (32'h0000_0003 << `C1_RES_LSB) | SW_GO);
        wait_irq;
        check(32'((when_q[1] - when_q[0]) / 25), 32'h0000_000b);
        rdc(`OFS_RESULT, 32'h0000_1000);
        $display("test resolution done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
